// ===== rtl/tsq_cfg.svh
`ifndef TSQ_CFG_SVH
`define TSQ_CFG_SVH

// Byte offsets inside the block's window
`define TSQ_OFS_LCB_LIMIT   8'h00
`define TSQ_OFS_ADJUST      8'h04
`define TSQ_OFS_LITERAL     8'h08
`define TSQ_OFS_QPTR        8'h0C
`define TSQ_OFS_QUE_FIRST   8'h10
`define TSQ_OFS_QUE_LAST    8'h2C
`define TSQ_OFS_TWA_LIMIT   8'h30
`define TSQ_OFS_TWB_LIMIT   8'h34
`define TSQ_OFS_LCA_LIMIT   8'h38
`define TSQ_OFS_SDL_LIMIT   8'h3C

// Field widths and reset values
`define TSQ_FIELD_W         16
`define TSQ_QPTR_W          5
`define TSQ_QUE_WORDS       8
`define TSQ_FIELD_RST       16'h0000
`define TSQ_QPTR_RST        5'h00
`define TSQ_QUE_RST         32'h0000_0000
`define TSQ_WORD_HSIZE      3'h2

// Sequencer output numbers routed off the block
`define TSQ_ADC_TRIG_LO     12
`define TSQ_ADC_TRIG_HI     15
`define TSQ_CAPDIV_OUT      9
`define TSQ_RPIN_LO         28
`define TSQ_RPIN_HI         31

`endif

// ===== rtl/tsq_pkg.sv
package tsq_pkg;

	typedef enum logic [2:0] {
		TSQ_TGT_TWA = 3'h0,
		TSQ_TGT_TWB = 3'h1,
		TSQ_TGT_LCA = 3'h2,
		TSQ_TGT_LCB = 3'h3,
		TSQ_TGT_SDL = 3'h4,
		TSQ_TGT_LIT = 3'h5
	} tsq_target_type;

	typedef enum logic [2:0] {
		TSQ_BUS_IDLE  = 3'b001,
		TSQ_BUS_WRITE = 3'b010,
		TSQ_BUS_READ  = 3'b100
	} tsq_bus_state_type;

endpackage : tsq_pkg

// ===== rtl/tsq_ahb_slave.sv
`include "tsq_cfg.svh"

module tsq_ahb_slave (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic             wr_en,
	output logic             rd_en,
	output logic [7:0]       acc_addr
);

	tsq_pkg::tsq_bus_state_type state_ff;
	tsq_pkg::tsq_bus_state_type nxt_state;
	logic [7:0]                 addr_ff;
	logic [7:0]                 nxt_addr;
	logic                       ready_ff;
	logic                       nxt_ready;
	logic                       take;

	// Reads take one wait state so read data leaves a flip-flop
	always_comb begin
		take      = hsel && hready && htrans[1];
		nxt_state = tsq_pkg::TSQ_BUS_IDLE;
		nxt_addr  = addr_ff;
		nxt_ready = 1'b1;
		if (take) begin
			nxt_addr = haddr[7:0];
			if (hwrite && hsize == `TSQ_WORD_HSIZE) begin
				nxt_state = tsq_pkg::TSQ_BUS_WRITE;
			end else if (!hwrite) begin
				nxt_state = tsq_pkg::TSQ_BUS_READ;
				nxt_ready = 1'b0;
			end
		end
		case (state_ff)
			tsq_pkg::TSQ_BUS_READ: begin
				nxt_state = tsq_pkg::TSQ_BUS_IDLE;
				nxt_ready = 1'b1;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= tsq_pkg::TSQ_BUS_IDLE;
			addr_ff  <= 8'h00;
			ready_ff <= 1'b1;
		end else if (ce) begin
			state_ff <= nxt_state;
			addr_ff  <= nxt_addr;
			ready_ff <= nxt_ready;
		end
	end

	assign hreadyout = ready_ff;
	assign hresp     = 1'b0;
	assign wr_en     = ce && state_ff == tsq_pkg::TSQ_BUS_WRITE;
	assign rd_en     = ce && state_ff == tsq_pkg::TSQ_BUS_READ;
	assign acc_addr  = addr_ff;

endmodule : tsq_ahb_slave

// ===== rtl/tsq_step_timer.sv
`include "tsq_cfg.svh"

module tsq_step_timer #(
	parameter int FIELD_W = `TSQ_FIELD_W
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               ce,
	input  wire logic               start,
	input  wire logic [FIELD_W-1:0] delay_limit,
	output logic                    busy,
	output logic                    done
);

	logic [FIELD_W-1:0] cnt_ff;
	logic [FIELD_W-1:0] nxt_cnt;
	logic               busy_ff;
	logic               nxt_busy;
	logic               done_ff;
	logic               nxt_done;

	// one base clock plus the extra delay clocks
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (busy_ff) begin
			if (cnt_ff == {FIELD_W{1'b0}}) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end else begin
				nxt_cnt = cnt_ff - {{(FIELD_W-1){1'b0}}, 1'b1};
			end
		end else if (start) begin
			nxt_cnt  = delay_limit;
			nxt_busy = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff  <= {FIELD_W{1'b0}};
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (ce) begin
			cnt_ff  <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;

endmodule : tsq_step_timer

// ===== rtl/tsq_regs.sv
`include "tsq_cfg.svh"

// Behaviour
// - The second loop-count limit is offered to the decoder as the jump iteration count or a general limit.
// - An add request adds the adjust value to the chosen target register and writes the sum back to it.
// - The add target is one of timer limit a, timer limit b, count limit a, count limit b, step delay, or literal.
// - A strobe-literal request puts the stored 16-bit literal onto the strobe output with a valid pulse.
// - A 5-bit software-writable queue pointer selects the command byte now being executed.
// - Eight queue words hold four command bytes each, byte 4n in bits 7-0 up to byte 4n+3 in bits 31-24.
// - Sequencer outputs 12 to 15 drive the ADC sample triggers and output 9 drives the capacitive divider input.
// - Sequencer outputs 28 to 31 drive the remappable pin outputs and all other outputs are unused.
// - Unimplemented bits read as zero and writes to them are dropped.
// - Each step lasts one clock plus the step delay limit in extra clocks.
module tsq_regs #(
	parameter int FIELD_W   = `TSQ_FIELD_W,
	parameter int QPTR_W    = `TSQ_QPTR_W,
	parameter int QUE_WORDS = `TSQ_QUE_WORDS
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               ce,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	input  wire logic               step_start,
	output logic                    step_busy,
	output logic                    step_done,
	input  wire logic               qptr_inc,
	output logic [7:0]              step_cmd_byte,
	input  wire logic               add_req,
	input  wire logic [2:0]         add_target,
	input  wire logic               strobe_req,
	output logic [FIELD_W-1:0]      strobe_data,
	output logic                    strobe_valid,
	output logic [FIELD_W-1:0]      twa_limit,
	output logic [FIELD_W-1:0]      twb_limit,
	output logic [FIELD_W-1:0]      lca_limit,
	output logic [FIELD_W-1:0]      lcb_limit,
	output logic [FIELD_W-1:0]      sdl_limit,
	input  wire logic [31:0]        seq_out,
	output logic [3:0]              adc_trig,
	output logic                    capdiv_trig,
	output logic [3:0]              rpin_out
);

	logic                 wr_en;
	logic                 rd_en;
	logic [7:0]           acc_addr;

	logic [FIELD_W-1:0]   twa_ff;
	logic [FIELD_W-1:0]   twb_ff;
	logic [FIELD_W-1:0]   lca_ff;
	logic [FIELD_W-1:0]   lcb_ff;
	logic [FIELD_W-1:0]   sdl_ff;
	logic [FIELD_W-1:0]   adj_ff;
	logic [FIELD_W-1:0]   lit_ff;
	logic [QPTR_W-1:0]    qptr_ff;
	logic [31:0]          que_ff [QUE_WORDS];
	logic [31:0]          hrdata_ff;
	logic [7:0]           cmd_ff;
	logic [FIELD_W-1:0]   sdata_ff;
	logic                 svalid_ff;
	logic [3:0]           adc_ff;
	logic                 capdiv_ff;
	logic [3:0]           rpin_ff;

	logic [FIELD_W-1:0]   nxt_twa;
	logic [FIELD_W-1:0]   nxt_twb;
	logic [FIELD_W-1:0]   nxt_lca;
	logic [FIELD_W-1:0]   nxt_lcb;
	logic [FIELD_W-1:0]   nxt_sdl;
	logic [FIELD_W-1:0]   nxt_adj;
	logic [FIELD_W-1:0]   nxt_lit;
	logic [QPTR_W-1:0]    nxt_qptr;
	logic [31:0]          nxt_que [QUE_WORDS];
	logic [31:0]          nxt_hrdata;
	logic [7:0]           nxt_cmd;
	logic [FIELD_W-1:0]   nxt_sdata;
	logic                 nxt_svalid;
	logic [3:0]           nxt_adc;
	logic                 nxt_capdiv;
	logic [3:0]           nxt_rpin;

	logic [FIELD_W-1:0]   wfield;
	logic [FIELD_W-1:0]   add_src;
	logic [FIELD_W-1:0]   add_sum;

	// Word index of a queue offset
	function automatic logic [2:0] que_index(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - `TSQ_OFS_QUE_FIRST;
		return rel[4:2];
	endfunction : que_index

	function automatic logic is_que(input logic [7:0] addr);
		return addr >= `TSQ_OFS_QUE_FIRST && addr <= `TSQ_OFS_QUE_LAST && addr[1:0] == 2'h0;
	endfunction : is_que

	// carry out of bit 15 dropped
	function automatic logic [FIELD_W-1:0] add_trunc(input logic [FIELD_W-1:0] a, input logic [FIELD_W-1:0] b);
		logic [FIELD_W:0] full;
		full = {1'b0, a} + {1'b0, b};
		return full[FIELD_W-1:0];
	endfunction : add_trunc

	function automatic logic [31:0] zext(input logic [FIELD_W-1:0] v);
		return {{(32-FIELD_W){1'b0}}, v};
	endfunction : zext

	tsq_ahb_slave u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wr_en     (wr_en),
		.rd_en     (rd_en),
		.acc_addr  (acc_addr)
	);

	tsq_step_timer #(
		.FIELD_W (FIELD_W)
	) u_step (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.ce          (ce),
		.start       (step_start),
		.delay_limit (sdl_ff),
		.busy        (step_busy),
		.done        (step_done)
	);

	// Register writes, add step and pointer
	always_comb begin
		nxt_twa  = twa_ff;
		nxt_twb  = twb_ff;
		nxt_lca  = lca_ff;
		nxt_lcb  = lcb_ff;
		nxt_sdl  = sdl_ff;
		nxt_adj  = adj_ff;
		nxt_lit  = lit_ff;
		nxt_qptr = qptr_ff;
		for (int i = 0; i < QUE_WORDS; i++) begin
			nxt_que[i] = que_ff[i];
		end
		// upper bits of the bus word discarded
		wfield = hwdata[FIELD_W-1:0];
		if (qptr_inc) begin
			nxt_qptr = qptr_ff + {{(QPTR_W-1){1'b0}}, 1'b1};
		end
		if (wr_en) begin
			if (acc_addr == `TSQ_OFS_LCB_LIMIT) begin
				nxt_lcb = wfield;
			end else if (acc_addr == `TSQ_OFS_ADJUST) begin
				nxt_adj = wfield;
			end else if (acc_addr == `TSQ_OFS_LITERAL) begin
				nxt_lit = wfield;
			end else if (acc_addr == `TSQ_OFS_QPTR) begin
				nxt_qptr = hwdata[QPTR_W-1:0];
			end else if (is_que(acc_addr)) begin
				nxt_que[que_index(acc_addr)] = hwdata;
			end else if (acc_addr == `TSQ_OFS_TWA_LIMIT) begin
				nxt_twa = wfield;
			end else if (acc_addr == `TSQ_OFS_TWB_LIMIT) begin
				nxt_twb = wfield;
			end else if (acc_addr == `TSQ_OFS_LCA_LIMIT) begin
				nxt_lca = wfield;
			end else if (acc_addr == `TSQ_OFS_SDL_LIMIT) begin
				nxt_sdl = wfield;
			end
		end
		case (tsq_pkg::tsq_target_type'(add_target))
			tsq_pkg::TSQ_TGT_TWA: add_src = twa_ff;
			tsq_pkg::TSQ_TGT_TWB: add_src = twb_ff;
			tsq_pkg::TSQ_TGT_LCA: add_src = lca_ff;
			tsq_pkg::TSQ_TGT_LCB: add_src = lcb_ff;
			tsq_pkg::TSQ_TGT_SDL: add_src = sdl_ff;
			default:              add_src = lit_ff;
		endcase
		add_sum = add_trunc(add_src, adj_ff);
		// sum written back, wins over a bus write
		if (add_req) begin
			case (tsq_pkg::tsq_target_type'(add_target))
				tsq_pkg::TSQ_TGT_TWA: nxt_twa = add_sum;
				tsq_pkg::TSQ_TGT_TWB: nxt_twb = add_sum;
				tsq_pkg::TSQ_TGT_LCA: nxt_lca = add_sum;
				tsq_pkg::TSQ_TGT_LCB: nxt_lcb = add_sum;
				tsq_pkg::TSQ_TGT_SDL: nxt_sdl = add_sum;
				tsq_pkg::TSQ_TGT_LIT: nxt_lit = add_sum;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			twa_ff  <= `TSQ_FIELD_RST;
			twb_ff  <= `TSQ_FIELD_RST;
			lca_ff  <= `TSQ_FIELD_RST;
			lcb_ff  <= `TSQ_FIELD_RST;
			sdl_ff  <= `TSQ_FIELD_RST;
			adj_ff  <= `TSQ_FIELD_RST;
			lit_ff  <= `TSQ_FIELD_RST;
			qptr_ff <= `TSQ_QPTR_RST;
			for (int i = 0; i < QUE_WORDS; i++) begin
				que_ff[i] <= `TSQ_QUE_RST;
			end
		end else if (ce) begin
			twa_ff  <= nxt_twa;
			twb_ff  <= nxt_twb;
			lca_ff  <= nxt_lca;
			lcb_ff  <= nxt_lcb;
			sdl_ff  <= nxt_sdl;
			adj_ff  <= nxt_adj;
			lit_ff  <= nxt_lit;
			qptr_ff <= nxt_qptr;
			for (int i = 0; i < QUE_WORDS; i++) begin
				que_ff[i] <= nxt_que[i];
			end
		end
	end

	// Read data, command byte, strobe and routing
	always_comb begin
		nxt_hrdata = hrdata_ff;
		if (rd_en) begin
			// unmapped and reserved bits read zero
			nxt_hrdata = 32'h0000_0000;
			if (acc_addr == `TSQ_OFS_LCB_LIMIT) begin
				nxt_hrdata = zext(lcb_ff);
			end else if (acc_addr == `TSQ_OFS_ADJUST) begin
				nxt_hrdata = zext(adj_ff);
			end else if (acc_addr == `TSQ_OFS_LITERAL) begin
				nxt_hrdata = zext(lit_ff);
			end else if (acc_addr == `TSQ_OFS_QPTR) begin
				nxt_hrdata = {{(32-QPTR_W){1'b0}}, qptr_ff};
			end else if (is_que(acc_addr)) begin
				nxt_hrdata = que_ff[que_index(acc_addr)];
			end else if (acc_addr == `TSQ_OFS_TWA_LIMIT) begin
				nxt_hrdata = zext(twa_ff);
			end else if (acc_addr == `TSQ_OFS_TWB_LIMIT) begin
				nxt_hrdata = zext(twb_ff);
			end else if (acc_addr == `TSQ_OFS_LCA_LIMIT) begin
				nxt_hrdata = zext(lca_ff);
			end else if (acc_addr == `TSQ_OFS_SDL_LIMIT) begin
				nxt_hrdata = zext(sdl_ff);
			end
		end
		nxt_cmd = que_ff[qptr_ff[4:2]][{qptr_ff[1:0], 3'h0} +: 8];
		// literal placed on the strobe path
		nxt_sdata  = strobe_req ? lit_ff : sdata_ff;
		nxt_svalid = strobe_req;
		nxt_adc    = seq_out[`TSQ_ADC_TRIG_HI:`TSQ_ADC_TRIG_LO];
		nxt_capdiv = seq_out[`TSQ_CAPDIV_OUT];
		nxt_rpin   = seq_out[`TSQ_RPIN_HI:`TSQ_RPIN_LO];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
			cmd_ff    <= 8'h00;
			sdata_ff  <= `TSQ_FIELD_RST;
			svalid_ff <= 1'b0;
			adc_ff    <= 4'h0;
			capdiv_ff <= 1'b0;
			rpin_ff   <= 4'h0;
		end else if (ce) begin
			hrdata_ff <= nxt_hrdata;
			cmd_ff    <= nxt_cmd;
			sdata_ff  <= nxt_sdata;
			svalid_ff <= nxt_svalid;
			adc_ff    <= nxt_adc;
			capdiv_ff <= nxt_capdiv;
			rpin_ff   <= nxt_rpin;
		end
	end

	assign hrdata        = hrdata_ff;
	assign step_cmd_byte = cmd_ff;
	assign strobe_data   = sdata_ff;
	assign strobe_valid  = svalid_ff;
	assign twa_limit     = twa_ff;
	assign twb_limit     = twb_ff;
	assign lca_limit     = lca_ff;
	// count limit b handed to the decoder
	assign lcb_limit     = lcb_ff;
	assign sdl_limit     = sdl_ff;
	assign adc_trig      = adc_ff;
	assign capdiv_trig   = capdiv_ff;
	assign rpin_out      = rpin_ff;

endmodule : tsq_regs

// ===== verification/tsq_far_model.sv
module tsq_far_model (
	input  wire logic		hclk,
	input  wire logic [3:0]	adc_trig,
	input  wire logic		capdiv_trig,
	input  wire logic [3:0]	rpin_out,
	output logic [8:0]		seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0]	seen_ff;
	logic [8:0]	nxt_seen;
	always_comb begin
		nxt_seen = {rpin_out, capdiv_trig, adc_trig};
	end
	// Captured late so a glitch free level is seen
	always_ff @(posedge hclk) begin
		seen_ff <= nxt_seen;
	end
	assign seen = seen_ff;
endmodule : tsq_far_model

// ===== verification/tsq_regs_sva.sv
module tsq_regs_chk #(
	parameter int FIELD_W = 16
) (
	input wire logic				hclk,
	input wire logic				hresetn,
	input wire logic				ce,
	input wire logic				hsel,
	input wire logic [1:0]			htrans,
	input wire logic				hwrite,
	input wire logic				hready,
	input wire logic				hreadyout,
	input wire logic				hresp,
	input wire logic				step_busy,
	input wire logic				step_done,
	input wire logic				add_req,
	input wire logic [2:0]			add_target,
	input wire logic				strobe_req,
	input wire logic [FIELD_W-1:0]	strobe_data,
	input wire logic				strobe_valid,
	input wire logic [FIELD_W-1:0]	twa_limit,
	input wire logic [FIELD_W-1:0]	lcb_limit,
	input wire logic [FIELD_W-1:0]	sdl_limit,
	input wire logic [31:0]			seq_out,
	input wire logic [3:0]			adc_trig,
	input wire logic				capdiv_trig,
	input wire logic [3:0]			rpin_out
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [FIELD_W:0]	busy_cnt_ff;
	logic [FIELD_W:0]	nxt_busy_cnt;
	// Busy length counter, cleared between steps
	always_comb begin
		nxt_busy_cnt = step_busy ? busy_cnt_ff + 1'b1 : '0;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_cnt_ff <= '0;
		end else if (ce) begin
			busy_cnt_ff <= nxt_busy_cnt;
		end
	end
	a_route_adc:
	assert property ($past(hresetn) && $past(ce) |->
		{adc_trig, capdiv_trig} == {$past(seq_out[15:12]), $past(seq_out[9])})
		else $error("adc or cvd route wrong");
	a_route_pps:
	assert property ($past(hresetn) && $past(ce) |-> rpin_out == $past(seq_out[31:28]))
		else $error("pin route wrong");
	a_read_wait:
	assert property (hsel && hready && htrans[1] && !hwrite && ce |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait:
	assert property (hsel && hready && htrans[1] && hwrite && ce |=> hreadyout)
		else $error("write stalled");
	a_resp_okay:
	assert property (hresp == 1'b0)
		else $error("error response");
	a_strobe_pulse:
	assert property (ce |=> strobe_valid == $past(strobe_req))
		else $error("strobe valid wrong");
	a_strobe_hold:
	assert property (ce && !strobe_req |=> $stable(strobe_data))
		else $error("strobe data moved");
	a_add_ignore:
	assert property (add_req && ce && add_target > 3'h5 |=> $stable(twa_limit) && $stable(lcb_limit))
		else $error("bad target changed a limit");
	a_step_len:
	assert property ($fell(step_busy) |-> busy_cnt_ff == sdl_limit + 1'b1)
		else $error("step length wrong");
	a_done_pulse:
	assert property ($fell(step_busy) |-> step_done ##1 !step_done)
		else $error("done pulse wrong");
endmodule : tsq_regs_chk

bind tsq_regs tsq_regs_chk #(.FIELD_W(FIELD_W)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .step_busy(step_busy), .step_done(step_done),
	.add_req(add_req), .add_target(add_target), .strobe_req(strobe_req), .strobe_data(strobe_data),
	.strobe_valid(strobe_valid), .twa_limit(twa_limit), .lcb_limit(lcb_limit), .sdl_limit(sdl_limit),
	.seq_out(seq_out), .adc_trig(adc_trig), .capdiv_trig(capdiv_trig), .rpin_out(rpin_out)
);

// ===== verification/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} tsq_row_type;
	logic			hclk, hresetn, ce, hsel, hwrite, step_start, qptr_inc, add_req, strobe_req;
	logic [31:0]	haddr, hwdata, seq_out, rd, hrdata;
	logic [1:0]		htrans;
	logic [2:0]		hsize, add_target;
	wire logic		hready;
	logic			hreadyout, hresp, step_busy, step_done, strobe_valid, capdiv_trig;
	logic [7:0]		step_cmd_byte;
	logic [15:0]	strobe_data, twa_limit, twb_limit, lca_limit, lcb_limit, sdl_limit;
	logic [3:0]		adc_trig, rpin_out;
	logic [8:0]		far_seen;
	int				n_fail, check_count, k;
	logic [7:0]		tgt_ofs [8] = '{8'h30, 8'h34, 8'h38, 8'h00, 8'h3C, 8'h08, 8'h00, 8'h3C};
	tsq_row_type	rows [8] = '{
		'{8'h00, 32'hFFFF_FFFF, 32'h0000_FFFF}, '{8'h04, 32'h1234_5678, 32'h0000_5678},
		'{8'h08, 32'hABCD_A5A5, 32'h0000_A5A5}, '{8'h0C, 32'hFFFF_FFFF, 32'h0000_001F},
		'{8'h10, 32'h4433_2211, 32'h4433_2211}, '{8'h2C, 32'h8899_AABB, 32'h8899_AABB},
		'{8'h3C, 32'h0000_0006, 32'h0000_0006}, '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000}};

	// One slave, so its ready is the bus ready
	assign hready = hreadyout;

	tsq_regs DUT (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .step_start(step_start), .step_busy(step_busy),
		.step_done(step_done), .qptr_inc(qptr_inc), .step_cmd_byte(step_cmd_byte), .add_req(add_req),
		.add_target(add_target), .strobe_req(strobe_req), .strobe_data(strobe_data),
		.strobe_valid(strobe_valid), .twa_limit(twa_limit), .twb_limit(twb_limit), .lca_limit(lca_limit),
		.lcb_limit(lcb_limit), .sdl_limit(sdl_limit), .seq_out(seq_out), .adc_trig(adc_trig),
		.capdiv_trig(capdiv_trig), .rpin_out(rpin_out));

	tsq_far_model u_far (.hclk(hclk), .adc_trig(adc_trig), .capdiv_trig(capdiv_trig), .rpin_out(rpin_out),
		.seen(far_seen));

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Ready judged at the negedge, where it is settled
	task automatic wait_rdy(output logic [31:0] d);
		int c;
		c = 0;
		@(negedge hclk);
		while (hreadyout !== 1'b1) begin
			c++;
			if (c > 20) begin
				n_fail++;
				close_out;
			end
			@(negedge hclk);
		end
		d = hrdata;
		@(posedge hclk);
	endtask : wait_rdy

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= 1'b1;
		wait_rdy(x);
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy(x);
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= 1'b0;
		wait_rdy(d);
		htrans <= 2'h0;
		wait_rdy(d);
	endtask : bus_rd

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	initial begin
		n_fail = 0;
		check_count = 0;
		hresetn <= 1'b0;
		ce <= 1'b1;
		hsel <= 1'b1;
		htrans <= 2'h0;
		haddr <= 32'h0;
		hwrite <= 1'b0;
		hsize <= 3'h2;
		hwdata <= 32'h0;
		step_start <= 1'b0;
		qptr_inc <= 1'b0;
		add_req <= 1'b0;
		add_target <= 3'h0;
		strobe_req <= 1'b0;
		seq_out <= 32'h0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) begin
			bus_wr(rows[i].a, rows[i].w);
			bus_rd(rows[i].a, rd);
			chk(rd, rows[i].r);
		end
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) begin
			bus_rd(rows[i].a, rd);
			chk(rd, 32'h0);
		end
		// Two adds of 0x8001 wrap to 0x0002; codes 6 and 7 leave their reads at 2
		bus_wr(8'h04, 32'h0000_8001);
		for (k = 0; k < 8; k++) begin
			add_target <= 3'(k);
			add_req <= 1'b1;
			repeat (2) @(posedge hclk);
			add_req <= 1'b0;
			bus_rd(tgt_ofs[k], rd);
			chk(rd, 32'h2);
		end
		chk({twa_limit, twb_limit}, 32'h0002_0002);
		chk({lca_limit, lcb_limit}, 32'h0002_0002);
		chk({16'h0000, sdl_limit}, 32'h0000_0002);
		strobe_req <= 1'b1;
		@(posedge hclk);
		strobe_req <= 1'b0;
		@(negedge hclk);
		chk({15'h0, strobe_valid, strobe_data}, 32'h0001_0002);
		@(posedge hclk);
		bus_wr(8'h3C, 32'h6);
		step_start <= 1'b1;
		@(posedge hclk);
		step_start <= 1'b0;
		k = 0;
		repeat (20) begin
			@(negedge hclk);
			k += (step_busy === 1'b1);
			k += (step_done === 1'b1) ? 100 : 0;
		end
		chk(k, 107);
		@(posedge hclk);
		bus_wr(8'h2C, 32'h8899_AABB);
		bus_wr(8'h0C, 32'h1F);
		repeat (3) @(posedge hclk);
		chk(step_cmd_byte, 8'h88);
		qptr_inc <= 1'b1;
		@(posedge hclk);
		qptr_inc <= 1'b0;
		bus_rd(8'h0C, rd);
		chk(rd, 32'h0);
		seq_out <= 32'hA5A5_A2A5;
		@(posedge hclk);
		seq_out <= 32'h0;
		@(negedge hclk);
		chk({adc_trig, capdiv_trig, rpin_out}, 9'h15A);
		@(negedge hclk);
		chk(far_seen, 9'h15A);
		// Enable low freezes routing and pointer
		@(posedge hclk);
		ce <= 1'b0;
		seq_out <= 32'h3000_C000;
		qptr_inc <= 1'b1;
		repeat (2) @(posedge hclk);
		ce <= 1'b1;
		qptr_inc <= 1'b0;
		@(negedge hclk);
		chk({adc_trig, capdiv_trig, rpin_out}, 9'h000);
		@(posedge hclk);
		seq_out <= 32'h0;
		@(negedge hclk);
		chk({adc_trig, capdiv_trig, rpin_out}, 9'h183);
		@(negedge hclk);
		chk(far_seen, 9'h06C);
		@(posedge hclk);
		bus_rd(8'h0C, rd);
		chk(rd, 32'h0);
		close_out;
	end
endmodule : tb_top
